//--- core/alhp_legacy_port.sv
////////////////////////////////////////////////////////////////////////////////
// Contract
// - Legacy mode fixes two receivers and one transmitter, not configurable.
// - Config word loads bits 14:0 from data bus while load strobe low; bit 15 stays zero.
// - Select high with read strobe low drives config word onto bus.
// - Select low with read strobe low drives status word onto bus.
// - Bits 0, 14, 13 pick rx1, rx2, tx rate: 0 fast, 1 slow.
// - Bit 1 enables label compare; sixteen labels loaded and read per receiver.
// - Bits 2 and 3 enable label recognition for receiver one and two.
// - Bit 4 makes the 32nd word bit parity instead of data.
// - Bit 5 resets high; low loops transmitter outputs into receivers.
// - Bit 6 makes receiver one require SDI equal to bits 8:7.
// - Bit 9 makes receiver two require SDI equal to bits 11:10.
// - Bit 12 picks transmitter parity: 0 odd, 1 even.
// - Status bits 0..2 show receiver one FIFO empty, half, full.
// - Status bits 3..5 show receiver two FIFO empty, half, full.
// - Status bits 6..8 show transmitter FIFO empty, full, half.
// - Host requests are sampled on the single master clock.
// - Config or status read data valid one cycle after sampling.
// - Data or label read data valid six cycles after sampling.
// - Writes complete two cycles after the request is sampled.
module alhp_legacy_port (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Legacy strobes
	input wire logic cfg_load_low,
	input wire logic register_select,
	input wire logic read_strobe_low,
	input wire logic label_load_rx_one_low,
	input wire logic label_load_rx_two_low,
	input wire logic label_read_rx_one_low,
	input wire logic label_read_rx_two_low,
	// Legacy data bus, split
	input wire logic [15:0] data_in,
	output logic [15:0] data_out,
	output logic data_oe_low,
	// FIFO flags
	input alhp_pkg::alhp_flags_t fifo_flags,
	// Receiver word filtering
	input alhp_pkg::alhp_rx_word_t rx_one_word,
	input alhp_pkg::alhp_rx_word_t rx_two_word,
	output logic rx_one_accept,
	output logic rx_two_accept,
	// Serial lines and loopback
	input wire logic [1:0] tx_line,
	input wire logic [1:0] rx_one_line,
	input wire logic [1:0] rx_two_line,
	output logic [1:0] rx_one_line_int,
	output logic [1:0] rx_two_line_int,
	// Channel settings
	output alhp_pkg::alhp_chan_ctrl_t chan_ctrl,
	// Host request port
	input wire logic host_rd,
	input wire logic host_wr,
	input alhp_pkg::alhp_kind_t host_kind,
	input wire logic [4:0] host_addr,
	input wire logic [31:0] host_wdata,
	input wire logic [31:0] host_ext_rdata,
	output logic host_stall,
	output logic [31:0] host_rdata,
	output logic host_rd_valid,
	// Transmit data write
	output logic tx_data_wr,
	output logic [31:0] tx_data
);

	alhp_pkg::alhp_state_t s_reg;
	alhp_pkg::alhp_state_t s_next;
	logic [1:0] ld_now;
	logic [1:0] rd_now;
	logic [1:0] hit;
	alhp_pkg::alhp_rx_word_t words [2];
	logic req;

	assign ld_now = {label_load_rx_two_low, label_load_rx_one_low};
	assign rd_now = {label_read_rx_two_low, label_read_rx_one_low};
	assign words[0] = rx_one_word;
	assign words[1] = rx_two_word;
	assign req = host_rd | host_wr;

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_next = s_reg;
		s_next.rvalid = 1'b0;
		s_next.txw = 1'b0;
		s_next.stat = fifo_flags;
		s_next.ld_prev = ld_now;
		s_next.rd_prev = rd_now;
		for (int i = 0; i < alhp_pkg::NUM_RX; i++) begin
			if (!s_reg.ld_prev[i] && ld_now[i]) begin
				s_next.labels[i][s_reg.wptr[i]] = data_in[7:0];
				s_next.wptr[i] = s_reg.wptr[i] + 4'h1;
			end
			if (!s_reg.rd_prev[i] && rd_now[i]) begin
				s_next.rptr[i] = s_reg.rptr[i] + 4'h1;
			end
		end
		// Bus read, registered so the bus never glitches
		s_next.doe_low = 1'b1;
		if (!read_strobe_low) begin
			s_next.doe_low = 1'b0;
			s_next.dout = register_select ? s_reg.cfg :
				{{alhp_pkg::STAT_PAD_W{1'b0}}, s_reg.stat};
		end else if (!label_read_rx_one_low) begin
			s_next.doe_low = 1'b0;
			s_next.dout = {8'h00, s_reg.labels[0][s_reg.rptr[0]]};
		end else if (!label_read_rx_two_low) begin
			s_next.doe_low = 1'b0;
			s_next.dout = {8'h00, s_reg.labels[1][s_reg.rptr[1]]};
		end
		// Host handshake
		unique case (s_reg.hst)
			alhp_pkg::H_IDLE: begin
				if (req) begin
					s_next.hst = alhp_pkg::H_BUSY;
					s_next.kind = host_kind;
					s_next.wr = host_wr;
					s_next.addr = host_addr;
					s_next.wdata = host_wdata;
					if (host_wr) begin
						s_next.cnt = alhp_pkg::LAT_WR - 3'h1;
					end else if (host_kind == alhp_pkg::KIND_CTRL) begin
						s_next.cnt = alhp_pkg::LAT_CTRL_RD - 3'h1;
					end else begin
						s_next.cnt = alhp_pkg::LAT_DATA_RD - 3'h1;
					end
				end
			end
			alhp_pkg::H_BUSY: begin
				if (s_reg.cnt != 3'h0) begin
					s_next.cnt = s_reg.cnt - 3'h1;
				end else begin
					s_next.hst = alhp_pkg::H_DONE;
					if (s_reg.wr) begin
						unique case (s_reg.kind)
							alhp_pkg::KIND_CTRL: begin
								s_next.cfg = s_reg.wdata[15:0] &
									alhp_pkg::CFG_MASK;
							end
							alhp_pkg::KIND_DATA: begin
								s_next.txw = 1'b1;
							end
							alhp_pkg::KIND_LABEL: begin
								s_next.labels[s_reg.addr[4]][s_reg.addr[3:0]] =
									s_reg.wdata[7:0];
							end
							default: begin
							end
						endcase
					end else begin
						s_next.rvalid = 1'b1;
						unique case (s_reg.kind)
							alhp_pkg::KIND_CTRL: begin
								s_next.rdata = s_reg.addr[0] ?
									{16'h0000, s_reg.cfg} :
									{23'h000000, s_reg.stat};
							end
							alhp_pkg::KIND_DATA: begin
								s_next.rdata = host_ext_rdata;
							end
							alhp_pkg::KIND_LABEL: begin
								s_next.rdata = {24'h000000,
									s_reg.labels[s_reg.addr[4]][s_reg.addr[3:0]]};
							end
							default: begin
								s_next.rdata = 32'h00000000;
							end
						endcase
					end
				end
			end
			alhp_pkg::H_DONE: begin
				// Wait for release so a held request is not retaken
				if (!req) begin
					s_next.hst = alhp_pkg::H_IDLE;
				end
			end
		endcase
		// Legacy load wins over a host write
		if (!cfg_load_low) begin
			s_next.cfg = data_in & alhp_pkg::CFG_MASK;
		end
		// Self test bit resets to normal
		if (reset) begin
			s_next = '0;
			s_next.cfg = alhp_pkg::CFG_RESET;
			s_next.doe_low = 1'b1;
			s_next.hst = alhp_pkg::H_IDLE;
			// Strobes idle high; a low history would fake a release
			s_next.ld_prev = '1;
			s_next.rd_prev = '1;
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		s_reg <= s_next;
	end

	////////////////////////////////////////////////////////////////////////////
	// Label match per receiver, all sixteen entries
	always_comb begin
		hit = 2'b00;
		for (int i = 0; i < alhp_pkg::NUM_RX; i++) begin
			for (int j = 0; j < alhp_pkg::NUM_LABELS; j++) begin
				if (s_reg.labels[i][j] == words[i].label) begin
					hit[i] = 1'b1;
				end
			end
		end
	end

	assign rx_one_accept = (!s_reg.cfg[alhp_pkg::CFG_RX1_SDI_EN] ||
		rx_one_word.sdi ==
		s_reg.cfg[alhp_pkg::CFG_RX1_SDI_LO +: 2]) &&
		(!(s_reg.cfg[alhp_pkg::CFG_LBL_CMP] &&
		s_reg.cfg[alhp_pkg::CFG_RX1_RECOG]) || hit[0]);
	assign rx_two_accept = (!s_reg.cfg[alhp_pkg::CFG_RX2_SDI_EN] ||
		rx_two_word.sdi ==
		s_reg.cfg[alhp_pkg::CFG_RX2_SDI_LO +: 2]) &&
		(!(s_reg.cfg[alhp_pkg::CFG_LBL_CMP] &&
		s_reg.cfg[alhp_pkg::CFG_RX2_RECOG]) || hit[1]);

	// Loopback when self test bit low
	assign rx_one_line_int = s_reg.cfg[alhp_pkg::CFG_NORMAL] ?
		rx_one_line : tx_line;
	assign rx_two_line_int = s_reg.cfg[alhp_pkg::CFG_NORMAL] ?
		rx_two_line : tx_line;

	assign chan_ctrl.rx1_slow = s_reg.cfg[alhp_pkg::CFG_RX1_RATE];
	assign chan_ctrl.rx2_slow = s_reg.cfg[alhp_pkg::CFG_RX2_RATE];
	assign chan_ctrl.tx_slow = s_reg.cfg[alhp_pkg::CFG_TX_RATE];
	assign chan_ctrl.par32 = s_reg.cfg[alhp_pkg::CFG_PAR32];
	assign chan_ctrl.tx_even = s_reg.cfg[alhp_pkg::CFG_TX_EVEN];
	assign chan_ctrl.loopback = !s_reg.cfg[alhp_pkg::CFG_NORMAL];

	// Outputs; stall is combinational so the first cycle already holds
	// Stall while request pending
	assign host_stall = (s_reg.hst == alhp_pkg::H_IDLE && req) ||
		s_reg.hst == alhp_pkg::H_BUSY;
	assign data_out = s_reg.dout;
	assign data_oe_low = s_reg.doe_low;
	assign host_rdata = s_reg.rdata;
	assign host_rd_valid = s_reg.rvalid;
	assign tx_data_wr = s_reg.txw;
	assign tx_data = s_reg.wdata;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	logic take;
	assign take = s_reg.hst == alhp_pkg::H_IDLE && req;

	a_cfg_load: assert property (
		!cfg_load_low |=> s_reg.cfg == ($past(data_in) & alhp_pkg::CFG_MASK))
		else $error("config load lost");
	a_cfg_read: assert property (
		!read_strobe_low && register_select |=>
		!data_oe_low && data_out == $past(s_reg.cfg))
		else $error("config read wrong");
	a_stat_read: assert property (
		!read_strobe_low && !register_select |=>
		!data_oe_low && data_out == {7'h00, $past(s_reg.stat)})
		else $error("status read wrong");
	a_loop_path: assert property (
		!s_reg.cfg[alhp_pkg::CFG_NORMAL] |-> rx_one_line_int == tx_line &&
		rx_two_line_int == tx_line)
		else $error("loopback not routed");
	a_sdi_one: assert property (
		s_reg.cfg[6] && rx_one_word.sdi != s_reg.cfg[8:7] |-> !rx_one_accept)
		else $error("rx one sdi passed");
	a_sdi_two: assert property (
		s_reg.cfg[9] && rx_two_word.sdi != s_reg.cfg[11:10] |-> !rx_two_accept)
		else $error("rx two sdi passed");
	a_fast_read: assert property (
		take && !host_wr && host_kind == alhp_pkg::KIND_CTRL |->
		##1 !host_rd_valid ##1 host_rd_valid)
		else $error("fast read latency");
	a_slow_read: assert property (
		take && !host_wr && host_kind == alhp_pkg::KIND_DATA |->
		##1 (!host_rd_valid)[*6] ##1 host_rd_valid)
		else $error("slow read latency");
	a_ctrl_write: assert property (
		take && host_wr && host_kind == alhp_pkg::KIND_CTRL ##2 cfg_load_low
		|=> s_reg.cfg == ($past(host_wdata[15:0], 3) & alhp_pkg::CFG_MASK))
		else $error("config write latency");
	a_stall_busy: assert property (
		take |-> host_stall ##1 (s_reg.hst == alhp_pkg::H_BUSY && host_stall))
		else $error("stall dropped");
	a_cfg_rsvd: assert property (
		!s_reg.cfg[15])
		else $error("config bit 15 set");

	c_fast_read: cover property (take && host_kind == alhp_pkg::KIND_CTRL);
	c_label_wr: cover property (take && host_wr &&
		host_kind == alhp_pkg::KIND_LABEL);
	c_data_rd: cover property (host_rd_valid && s_reg.kind ==
		alhp_pkg::KIND_DATA);
	c_loopback: cover property (chan_ctrl.loopback);

endmodule

//--- core/alhp_pkg.sv
package alhp_pkg;

	// Master clock rate the bit timing is built for
	localparam int unsigned CLK_HZ = 20_000_000;

	// Configuration word: reset value and writable bits
	localparam logic [15:0] CFG_RESET = 16'h0020;
	localparam logic [15:0] CFG_MASK = 16'h7fff;

	// Configuration bit positions
	localparam int CFG_RX1_RATE = 0;
	localparam int CFG_LBL_CMP = 1;
	localparam int CFG_RX1_RECOG = 2;
	localparam int CFG_RX2_RECOG = 3;
	localparam int CFG_PAR32 = 4;
	localparam int CFG_NORMAL = 5;
	localparam int CFG_RX1_SDI_EN = 6;
	localparam int CFG_RX1_SDI_LO = 7;
	localparam int CFG_RX2_SDI_EN = 9;
	localparam int CFG_RX2_SDI_LO = 10;
	localparam int CFG_TX_EVEN = 12;
	localparam int CFG_TX_RATE = 13;
	localparam int CFG_RX2_RATE = 14;

	// Status word padding above the nine flags
	localparam int STAT_PAD_W = 7;

	// Label memories: two receivers, sixteen labels each
	localparam int NUM_RX = 2;
	localparam int NUM_LABELS = 16;

	// Host access latencies in clock cycles after sampling
	localparam logic [2:0] LAT_CTRL_RD = 3'h1;
	localparam logic [2:0] LAT_DATA_RD = 3'h6;
	localparam logic [2:0] LAT_WR = 3'h2;

	// Host request target
	typedef enum logic [1:0] {
		KIND_CTRL,
		KIND_DATA,
		KIND_LABEL
	} alhp_kind_t;

	// Host handshake states
	typedef enum logic [1:0] {
		H_IDLE,
		H_BUSY,
		H_DONE
	} alhp_hstate_t;

	// FIFO flags in status bit order, bit 0 last
	typedef struct packed {
		logic tx_half;
		logic tx_full;
		logic tx_empty;
		logic rx2_full;
		logic rx2_half;
		logic rx2_empty;
		logic rx1_full;
		logic rx1_half;
		logic rx1_empty;
	} alhp_flags_t;

	// Header of a received word: SDI is ARINC bits 10:9
	typedef struct packed {
		logic [1:0] sdi;
		logic [7:0] label;
	} alhp_rx_word_t;

	// Channel settings decoded from the configuration word
	typedef struct packed {
		logic rx1_slow;
		logic rx2_slow;
		logic tx_slow;
		logic par32;
		logic tx_even;
		logic loopback;
	} alhp_chan_ctrl_t;

	// Whole state of the port
	typedef struct packed {
		logic [15:0] cfg;
		alhp_flags_t stat;
		logic [NUM_RX-1:0][NUM_LABELS-1:0][7:0] labels;
		logic [NUM_RX-1:0][3:0] wptr;
		logic [NUM_RX-1:0][3:0] rptr;
		logic [NUM_RX-1:0] ld_prev;
		logic [NUM_RX-1:0] rd_prev;
		logic [15:0] dout;
		logic doe_low;
		alhp_hstate_t hst;
		logic [2:0] cnt;
		alhp_kind_t kind;
		logic wr;
		logic [4:0] addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic rvalid;
		logic txw;
	} alhp_state_t;

endpackage

//--- tb/alhp_host_model.sv
module alhp_host_model (
	// Clock
	input wire logic mclk,
	// Answers from the port
	input wire logic host_stall,
	input wire logic host_rd_valid,
	input wire logic tx_data_wr,
	input wire logic [31:0] host_rdata,
	// Requests
	output logic host_rd,
	output logic host_wr,
	output alhp_pkg::alhp_kind_t host_kind,
	output logic [4:0] host_addr,
	output logic [31:0] host_wdata,
	output logic [31:0] host_ext_rdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle host at time zero
	initial begin
		host_rd = 1'b0;
		host_wr = 1'b0;
		host_kind = alhp_pkg::KIND_CTRL;
		host_addr = 5'h00;
		host_wdata = 32'h0;
		host_ext_rdata = 32'h0;
	end

	////////////////////////////////////////
	// One transfer; d also feeds the data read source
	task automatic xfer(input logic wr, input alhp_pkg::alhp_kind_t k,
		input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q, output int lat, output logic seen);
		int n;
		n = 0;
		host_wr = wr;
		host_rd = !wr;
		host_kind = k;
		host_addr = a;
		host_wdata = d;
		host_ext_rdata = d;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (host_stall === 1'b1 && n < 20);
		lat = n - 1;
		q = host_rdata;
		seen = wr ? tx_data_wr : host_rd_valid;
		@(posedge mclk);
		#1;
		host_rd = 1'b0;
		host_wr = 1'b0;
		// Released lines must not keep the old value
		host_wdata = ~d;
		host_ext_rdata = ~d;
		@(posedge mclk);
		#1;
	endtask
endmodule

//--- tb/test_arinc_host_port_legacy_regs.sv
module test_arinc_host_port_legacy_regs;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, reset, cfg_load_low, register_select, read_strobe_low;
	logic label_load_rx_one_low, label_load_rx_two_low;
	logic label_read_rx_one_low, label_read_rx_two_low;
	logic [15:0] data_in, data_out;
	logic data_oe_low, rx_one_accept, rx_two_accept;
	logic host_stall, host_rd_valid, tx_data_wr, host_rd, host_wr;
	logic [1:0] tx_line, rx_one_line, rx_two_line;
	logic [1:0] rx_one_line_int, rx_two_line_int;
	logic [4:0] host_addr;
	logic [31:0] host_wdata, host_ext_rdata, host_rdata, tx_data;
	alhp_pkg::alhp_flags_t fifo_flags;
	alhp_pkg::alhp_rx_word_t rx_one_word, rx_two_word;
	alhp_pkg::alhp_chan_ctrl_t chan_ctrl;
	alhp_pkg::alhp_kind_t host_kind;
	int fails, n_tests;
	int pos[5] = '{0, 14, 13, 4, 12};

	alhp_legacy_port uut (.mclk, .reset, .cfg_load_low, .register_select,
		.read_strobe_low, .label_load_rx_one_low, .label_load_rx_two_low,
		.label_read_rx_one_low, .label_read_rx_two_low, .data_in, .data_out,
		.data_oe_low, .fifo_flags, .rx_one_word, .rx_two_word, .rx_one_accept,
		.rx_two_accept, .tx_line, .rx_one_line, .rx_two_line,
		.rx_one_line_int, .rx_two_line_int, .chan_ctrl, .host_rd, .host_wr,
		.host_kind, .host_addr, .host_wdata, .host_ext_rdata, .host_stall,
		.host_rdata, .host_rd_valid, .tx_data_wr, .tx_data);
	alhp_host_model host (.mclk, .host_stall, .host_rd_valid, .tx_data_wr,
		.host_rdata, .host_rd, .host_wr, .host_kind, .host_addr, .host_wdata,
		.host_ext_rdata);

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	////////////////////////////////////////
	task automatic chk(input logic [31:0] g, e, input string m);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask
	task automatic chk_n(input int g, e, input string m);
		n_tests++;
		if (g != e) begin
			fails++;
			$display("wrong value at %0t: %s got %0d want %0d", $time, m, g, e);
		end
	endtask
	task automatic tick;
		@(posedge mclk);
		#1;
	endtask
	task automatic cfg_load(input logic [15:0] v);
		data_in = v;
		cfg_load_low = 1'b0;
		tick;
		cfg_load_low = 1'b1;
		tick;
	endtask
	task automatic leg_read(input logic sel, input logic [15:0] e);
		register_select = sel;
		read_strobe_low = 1'b0;
		tick;
		chk({31'h0, data_oe_low}, 32'h0, "bus not driven");
		chk({16'h0, data_out}, {16'h0, e}, "legacy read");
		read_strobe_low = 1'b1;
		tick;
	endtask
	// Label written on strobe release, data still on the bus
	task automatic lbl_load(input int r, input logic [7:0] v);
		data_in = {8'h00, v};
		label_load_rx_one_low = (r != 0);
		label_load_rx_two_low = (r == 0);
		tick;
		label_load_rx_one_low = 1'b1;
		label_load_rx_two_low = 1'b1;
		tick;
	endtask
	task automatic lbl_read(input int r, input logic [7:0] e);
		label_read_rx_one_low = (r != 0);
		label_read_rx_two_low = (r == 0);
		tick;
		chk({16'h0, data_out}, {24'h0, e}, "label read");
		label_read_rx_one_low = 1'b1;
		label_read_rx_two_low = 1'b1;
		tick;
	endtask
	task automatic words(input logic [1:0] s, input logic [7:0] l);
		rx_one_word = {s, l};
		rx_two_word = {s, l};
		#1;
	endtask
	task automatic acc(input logic [1:0] e);
		chk({30'h0, rx_two_accept, rx_one_accept}, {30'h0, e}, "accept");
	endtask
	task automatic hx(input logic wr, input alhp_pkg::alhp_kind_t k,
		input logic [4:0] a, input logic [31:0] d, e, input int l);
		logic [31:0] q;
		int lat;
		logic seen;
		host.xfer(wr, k, a, d, q, lat, seen);
		chk_n(lat, l, "latency");
		// Only a data register write pulses the transmit strobe
		chk({31'h0, seen}, {31'h0, !wr || k == alhp_pkg::KIND_DATA},
			"completion pulse");
		if (!wr)
			chk(q, e, "host read");
	endtask
	task automatic close_out;
		if (fails == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Watchdog, far beyond the 130 or so cycles the tests need
	initial begin
		#100000;
		fails++;
		close_out;
	end

	////////////////////////////////////////
	initial begin
		{reset, cfg_load_low, read_strobe_low} = 3'b111;
		{label_load_rx_one_low, label_load_rx_two_low} = 2'b11;
		{label_read_rx_one_low, label_read_rx_two_low} = 2'b11;
		register_select = 1'b0;
		data_in = 16'h0;
		fifo_flags = '0;
		rx_one_word = '0;
		rx_two_word = '0;
		{tx_line, rx_one_line, rx_two_line} = 6'h0;
		fails = 0;
		n_tests = 0;
		repeat (10) @(posedge mclk);
		#1;
		reset = 1'b0;
		tick;
		leg_read(1'b1, 16'h0020);
		leg_read(1'b0, 16'h0000);
		for (int i = 0; i < 9; i++) begin
			fifo_flags = 9'h001 << i;
			tick;
			leg_read(1'b0, 16'h0001 << i);
		end
		fifo_flags = 9'h1ff;
		tick;
		leg_read(1'b0, 16'h01ff);
		cfg_load(16'hffff);
		leg_read(1'b1, 16'h7fff);
		chk({26'h0, chan_ctrl}, 32'h3e, "decode");
		for (int i = 0; i < 5; i++) begin
			cfg_load(16'h0020 | (16'h0001 << pos[i]));
			chk({26'h0, chan_ctrl}, 32'h20 >> i, "decode");
		end
		cfg_load(16'h0000);
		{tx_line, rx_one_line, rx_two_line} = 6'b10_01_01;
		#1;
		chk({30'h0, rx_one_line_int}, 32'h2, "loop rx1");
		chk({30'h0, rx_two_line_int}, 32'h2, "loop rx2");
		cfg_load(16'h0020);
		chk({28'h0, rx_one_line_int, rx_two_line_int}, 32'h5, "normal");
		// SDI filter per receiver, the other one stays open
		for (int r = 0; r < 2; r++) begin
			cfg_load(r ? 16'h0a20 : 16'h0160);
			words(2'b10, 8'h77);
			acc(2'b11);
			words(2'b01, 8'h77);
			acc(r ? 2'b01 : 2'b10);
		end
		cfg_load(16'h0020);
		acc(2'b11);
		// Both receivers exist with their own label memories
		lbl_load(0, 8'h5a);
		lbl_load(1, 8'h6b);
		lbl_read(0, 8'h5a);
		lbl_read(1, 8'h6b);
		cfg_load(16'h0026);
		words(2'b00, 8'h5a);
		acc(2'b11);
		words(2'b00, 8'h33);
		acc(2'b10);
		cfg_load(16'h0024);
		acc(2'b11);
		cfg_load(16'h002a);
		acc(2'b01);
		words(2'b00, 8'h6b);
		acc(2'b11);
		hx(1'b1, alhp_pkg::KIND_CTRL, 5'h01, 32'h9234, 32'h0, 2);
		leg_read(1'b1, 16'h1234);
		hx(1'b0, alhp_pkg::KIND_CTRL, 5'h01, 32'h0, 32'h1234, 1);
		hx(1'b0, alhp_pkg::KIND_CTRL, 5'h00, 32'h0, 32'h01ff, 1);
		hx(1'b1, alhp_pkg::KIND_DATA, 5'h00, 32'hdead0001, 32'h0, 2);
		chk(tx_data, 32'hdead0001, "tx data");
		hx(1'b0, alhp_pkg::KIND_DATA, 5'h00, 32'h5eed1234, 32'h5eed1234, 6);
		hx(1'b1, alhp_pkg::KIND_LABEL, 5'h13, 32'ha5, 32'h0, 2);
		hx(1'b0, alhp_pkg::KIND_LABEL, 5'h13, 32'h0, 32'ha5, 6);
		close_out;
	end
endmodule
